/* hw/lcch_cmd_handler.sv */
// Notes on behaviour
// - Command 0x74+ch returns filtered 24-bit sample, three bytes LSB first, then zero.
// - Command 0x70+ch returns float weight, four bytes LSB first, then zero.
// - Weight equals scale times K times filtered sample minus zero offset.
// - Each weight is compared with its setpoint and steers its output per mode.
// - Command 0x4C returns outputs in bits 0-3, inverted inputs in 4-7, zero.
// - Command 0x50 takes one byte, low nibble drives outputs, then zero.
// - Outputs written by host are volatile; reset clears them.
// - Command 0x7C+ch takes filter length 1, 2, 4 or 8 samples.
// - Any other filter value sets length to one.
// - Filter setting is applied and its save requested as the zero acknowledge is loaded.
// - A changed filter setting purges history; the old sample stays until refilled.
// - Command 0x78+ch returns filter length byte, then zero.
// - Command 0x54 returns channel active flags in bits 0-3, then zero.
// - Command 0x58 takes active flags, saves them, then sends zero.
// - Command 0x80 returns mode byte then zero; set bit means weight control.
// - Only an active channel may control its output by weight.
// - Low two command bits select the channel on channel commands.
// - Host write sets input-full; device read clears it.
// - A byte left unserved for 750 us abandons the command.
//
// The register addresses and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "lcch_regs.svh"
module lcch_cmd_handler
	import lcch_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = `LCCH_TIMEOUT_US * 1000 / `LCCH_CLK_NS
)
(
	// Clock and reset
	input logic clk,
	input logic rst_b,
	// AHB-Lite slave, host dataport
	input logic hsel,
	input logic [31:0] haddr,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic [2:0] hsize,
	input logic [31:0] hwdata,
	input logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Converter results, same clock
	input logic sampleValid,
	input logic [1:0] sampleCh,
	input logic [23:0] sampleData,
	// Calibration, setpoints and mode, same clock
	input logic [3:0][31:0] calScale,
	input logic [3:0][31:0] calK,
	input logic [3:0][31:0] calZero,
	input logic [3:0][31:0] setpoint,
	input logic [3:0] modeBits,
	// Digital pins
	input logic [3:0] inPins,
	output logic [3:0] outPins,
	// Nonvolatile save request
	output logic nvmSave,
	output logic nvmSel,
	output logic [1:0] nvmCh,
	output logic [7:0] nvmData
);
	localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

	if (TIMEOUT_CYCLES < 2)
	begin : g_chk
		$error("lcch_cmd_handler: timeout too short");
	end

	function automatic logic [31:0] i2f(input logic signed [32:0] v);
		logic [32:0] mag;
		logic [32:0] sh;
		logic [5:0] msb;
		mag = v[32] ? 33'(-v) : v;
		msb = 6'h00;
		for (int i = 0; i < 33; i++)
		begin
			if (mag[i])
			begin
				msb = 6'(i);
			end
		end
		sh = mag << (6'h20 - msb);
		i2f = (mag == 33'h0) ? 32'h0 : {v[32], 8'({2'h0, msb} + 8'h7F), sh[31:9]};
	endfunction

	// Truncating multiply; denormals flush to zero, overflow gives infinity
	function automatic logic [31:0] fmul(input logic [31:0] a, input logic [31:0] b);
		logic [47:0] p;
		logic signed [9:0] e;
		p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
		e = $signed(10'({2'h0, a[30:23]} + {2'h0, b[30:23]} + {9'h0, p[47]} - 10'h07F));
		if (a[30:23] == 8'h00 || b[30:23] == 8'h00 || e <= 10'sh000)
			fmul = {a[31] ^ b[31], 31'h0};
		else if (e >= 10'sh0FF)
			fmul = {a[31] ^ b[31], 8'hFF, 23'h0};
		else
			fmul = {a[31] ^ b[31], e[7:0], p[47] ? p[46:24] : p[45:23]};
	endfunction

	function automatic logic fge(input logic [31:0] w, input logic [31:0] s);
		if (w[31] != s[31])
			fge = !w[31] || (w[30:0] == 31'h0 && s[30:0] == 31'h0);
		else if (!w[31])
			fge = w[30:0] >= s[30:0];
		else
			fge = w[30:0] <= s[30:0];
	endfunction

	lcch_state_type stateQ;
	logic [7:0] cmdQ, rxByteQ, inByteQ, outByteQ;
	logic inFullQ, outFullQ, wrPendQ, wrDataQ;
	logic [31:0] txShiftQ;
	logic [2:0] txLeftQ;
	logic [TW-1:0] timerQ;
	logic [3:0] pinS1Q, pinS2Q, activeQ, outQ;
	logic [3:0] filtLenQ [4];
	logic [26:0] sumQ [4];
	logic [3:0] fillQ [4];
	logic [2:0] wpQ [4];
	logic [23:0] filtQ [4];
	lcch_float_type weightQ [4];
	logic s1Q, wtPendQ;
	logic [1:0] s1ChQ, wtChQ;
	logic [23:0] s1ValQ, memRd;

	// Command decode of the byte waiting in the dataport
	logic [7:0] grp, cGrp;
	logic [1:0] ch, cCh;
	logic [2:0] txLen;
	logic [31:0] txWord;
	logic isWr;
	always_comb
	begin
		grp = {inByteQ[7:2], 2'h0};
		ch = inByteQ[1:0];
		txLen = 3'h0;
		txWord = 32'h0;
		isWr = 1'b0;
		case (grp)
			`LCCH_READ_WEIGHT_CMD: begin txLen = `LCCH_LEN_WEIGHT; txWord = weightQ[ch]; end
			`LCCH_READ_FILTERED_SAMPLE_CMD: begin txLen = `LCCH_LEN_SAMPLE; txWord = {8'h00, filtQ[ch]}; end
			`LCCH_READ_FILTER_LENGTH_CMD: begin txLen = `LCCH_LEN_BYTE; txWord = {28'h0, filtLenQ[ch]}; end
			`LCCH_READ_OUTPUT_CONTROL_CMD: begin txLen = `LCCH_LEN_BYTE; txWord = {28'h0, modeBits}; end
			`LCCH_READ_IO_CMD: begin txLen = `LCCH_LEN_BYTE; txWord = {24'h0, ~pinS2Q, outQ}; end
			`LCCH_READ_CHANNEL_ACTIVE_CMD: begin txLen = `LCCH_LEN_BYTE; txWord = {28'h0, activeQ}; end
			`LCCH_WRITE_FILTER_LENGTH_CMD, `LCCH_WRITE_OUTPUTS_CMD,
				`LCCH_WRITE_CHANNEL_ACTIVE_CMD: isWr = 1'b1;
			default: isWr = 1'b0;
		endcase
		cGrp = {cmdQ[7:2], 2'h0};
		cCh = cmdQ[1:0];
	end

	logic takeCmd, takeData, txLoad, ackLoad, timeout, commit, stall;
	logic accept, hostRd, hostWr, fCommit, aCommit, oCommit, fValid;
	logic [3:0] newLen;
	assign takeCmd = stateQ == ST_IDLE && inFullQ;
	assign takeData = stateQ == ST_RX && inFullQ;
	assign txLoad = stateQ == ST_TX && !outFullQ;
	assign ackLoad = stateQ == ST_ACK && !outFullQ;
	// Only a stall still in progress may expire; a byte served on the last cycle loses to the timeout
	assign stall = (stateQ == ST_RX && !inFullQ) || outFullQ;
	assign timeout = stall && timerQ == TW'(TIMEOUT_CYCLES - 1);
	assign commit = ackLoad && (cGrp == `LCCH_WRITE_FILTER_LENGTH_CMD
		|| cGrp == `LCCH_WRITE_OUTPUTS_CMD || cGrp == `LCCH_WRITE_CHANNEL_ACTIVE_CMD);
	assign fCommit = commit && cGrp == `LCCH_WRITE_FILTER_LENGTH_CMD;
	assign aCommit = commit && cGrp == `LCCH_WRITE_CHANNEL_ACTIVE_CMD;
	assign oCommit = commit && cGrp == `LCCH_WRITE_OUTPUTS_CMD;
	assign fValid = rxByteQ == 8'h01 || rxByteQ == 8'h02 || rxByteQ == 8'h04 || rxByteQ == 8'h08;
	assign newLen = fValid ? rxByteQ[3:0] : `LCCH_FILT_RST;
	assign accept = hsel && htrans[1] && hready;
	assign hostRd = accept && !hwrite && haddr[7:0] == `LCCH_OFS_DATA;
	assign hostWr = wrPendQ && wrDataQ;

	// Command sequencer; a timeout drops the transfer without a terminator
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			stateQ <= ST_IDLE;
			cmdQ <= 8'h00;
			rxByteQ <= 8'h00;
			txShiftQ <= 32'h0;
			txLeftQ <= 3'h0;
		end
		else if (timeout)
			stateQ <= ST_IDLE;
		else
			unique case (stateQ)
				ST_IDLE:
					if (inFullQ)
					begin
						cmdQ <= inByteQ;
						txShiftQ <= txWord;
						txLeftQ <= txLen;
						if (txLen != 3'h0)
							stateQ <= ST_TX;
						else if (isWr)
							stateQ <= ST_RX;
					end
				ST_TX:
					if (!outFullQ)
					begin
						txShiftQ <= txShiftQ >> 8;
						txLeftQ <= txLeftQ - 3'h1;
						if (txLeftQ == 3'h1)
							stateQ <= ST_ACK;
					end
				ST_RX:
					if (inFullQ)
					begin
						rxByteQ <= inByteQ;
						stateQ <= ST_ACK;
					end
				ST_ACK:
					if (!outFullQ)
						stateQ <= ST_IDLE;
			endcase
	end

	// Input-full flag; a host write wins over the device read
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			inFullQ <= 1'b0;
			inByteQ <= 8'h00;
		end
		else if (hostWr)
		begin
			inFullQ <= 1'b1;
			inByteQ <= hwdata[7:0];
		end
		else if (takeCmd || takeData)
			inFullQ <= 1'b0;
	end

	// Output-full flag and presented byte
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			outFullQ <= 1'b0;
			outByteQ <= 8'h00;
		end
		else if (txLoad || ackLoad)
		begin
			outFullQ <= 1'b1;
			outByteQ <= txLoad ? txShiftQ[7:0] : `LCCH_ACK_BYTE;
		end
		else if (hostRd || timeout)
			outFullQ <= 1'b0;
	end

	// Host stall watchdog
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			timerQ <= '0;
		else if (stall)
			timerQ <= timeout ? '0 : timerQ + TW'(1);
		else
			timerQ <= '0;
	end

	// AHB-Lite: zero wait states, always OKAY, unmapped reads give zero
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wrPendQ <= 1'b0;
			wrDataQ <= 1'b0;
			hrdata <= 32'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			wrPendQ <= accept && hwrite;
			wrDataQ <= haddr[7:0] == `LCCH_OFS_DATA;
			if (accept && !hwrite)
				case (haddr[7:0])
					`LCCH_OFS_DATA: hrdata <= {24'h0, outByteQ};
					`LCCH_OFS_STAT: hrdata <= {29'h0, stateQ != ST_IDLE, outFullQ, inFullQ};
					default: hrdata <= 32'h0;
				endcase
		end
	end

	// Pin inputs
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pinS1Q <= 4'h0;
			pinS2Q <= 4'h0;
		end
		else
		begin
			pinS1Q <= inPins;
			pinS2Q <= pinS1Q;
		end
	end

	// Stored settings and their save requests
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			activeQ <= `LCCH_ACT_RST;
			for (int i = 0; i < 4; i++)
				filtLenQ[i] <= `LCCH_FILT_RST;
			nvmSave <= 1'b0;
			nvmSel <= 1'b0;
			nvmCh <= 2'h0;
			nvmData <= 8'h00;
		end
		else
		begin
			nvmSave <= fCommit || aCommit;
			nvmSel <= aCommit ? `LCCH_NVM_ACT : `LCCH_NVM_FILT;
			nvmCh <= cCh;
			nvmData <= aCommit ? {4'h0, rxByteQ[3:0]} : {4'h0, newLen};
			if (fCommit)
				filtLenQ[cCh] <= newLen;
			if (aCommit)
				activeQ <= rxByteQ[3:0];
		end
	end

	// Moving average; samples of one channel must be two cycles apart
	logic [3:0] len;
	logic [1:0] shAmt;
	logic full;
	logic [26:0] newSum;
	always_comb
	begin
		len = filtLenQ[s1ChQ];
		shAmt = {len[3] | len[2], len[3] | len[1]};
		full = fillQ[s1ChQ] == len;
		newSum = sumQ[s1ChQ] + {3'h0, s1ValQ} - (full ? {3'h0, memRd} : 27'h0);
	end

	lcch_hist_mem #(.AW(5), .DW(24)) u_hist
	(
		.clk(clk),
		.wrEn(s1Q),
		.wrAddr({s1ChQ, wpQ[s1ChQ]}),
		.wrData(s1ValQ),
		.rdAddr({sampleCh, wpQ[sampleCh]}),
		.rdData(memRd)
	);

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s1Q <= 1'b0;
			s1ChQ <= 2'h0;
			s1ValQ <= 24'h0;
			wtPendQ <= 1'b0;
			wtChQ <= 2'h0;
			for (int i = 0; i < 4; i++)
			begin
				sumQ[i] <= 27'h0;
				fillQ[i] <= 4'h0;
				wpQ[i] <= 3'h0;
				filtQ[i] <= 24'h0;
			end
		end
		else
		begin
			// Inactive channels take no measurement
			s1Q <= sampleValid && activeQ[sampleCh];
			s1ChQ <= sampleCh;
			s1ValQ <= sampleData;
			wtPendQ <= 1'b0;
			wtChQ <= s1ChQ;
			if (s1Q)
			begin
				sumQ[s1ChQ] <= newSum;
				wpQ[s1ChQ] <= (wpQ[s1ChQ] + 3'h1) & 3'(len - 4'h1);
				if (!full)
					fillQ[s1ChQ] <= fillQ[s1ChQ] + 4'h1;
				if (full || fillQ[s1ChQ] + 4'h1 == len)
				begin
					filtQ[s1ChQ] <= 24'(newSum >> shAmt);
					wtPendQ <= 1'b1;
				end
			end
			// Old result stays readable until the history refills
			if (fCommit && newLen != filtLenQ[cCh])
			begin
				sumQ[cCh] <= 27'h0;
				fillQ[cCh] <= 4'h0;
				wpQ[cCh] <= 3'h0;
				if (s1Q && s1ChQ == cCh)
					wtPendQ <= 1'b0;
			end
		end
	end

	// Weight: one cycle after a new filtered sample
	logic signed [32:0] diff;
	lcch_float_type wtNew;
	logic [3:0] geVec;
	always_comb
	begin
		diff = $signed({9'h000, filtQ[wtChQ]}) - $signed({1'b0, calZero[wtChQ]});
		wtNew = fmul(fmul(calScale[wtChQ], calK[wtChQ]), i2f(diff));
		for (int i = 0; i < 4; i++)
			geVec[i] = fge(weightQ[i], setpoint[i]);
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			for (int i = 0; i < 4; i++)
				weightQ[i] <= 32'h0;
		else if (wtPendQ)
			weightQ[wtChQ] <= wtNew;
	end

	// Outputs: host value unless an active channel controls by weight
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			outQ <= 4'h0;
		else
		begin
			if (oCommit)
				outQ <= rxByteQ[3:0];
			for (int i = 0; i < 4; i++)
				if (modeBits[i] && activeQ[i])
					outQ[i] <= geVec[i];
		end
	end
	assign outPins = outQ;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_ack_sent;
		ackLoad ##1 (outFullQ && outByteQ == `LCCH_ACK_BYTE);
	endsequence

	a_sample_len: assert property (takeCmd && grp == `LCCH_READ_FILTERED_SAMPLE_CMD
		|=> stateQ == ST_TX && txLeftQ == 3'h3 && txShiftQ[31:24] == 8'h00)
		else $error("sample read length wrong");
	a_weight_len: assert property (takeCmd && grp == `LCCH_READ_WEIGHT_CMD
		|=> stateQ == ST_TX && txLeftQ == 3'h4)
		else $error("weight read length wrong");
	a_weight_math: assert property (wtPendQ |=> weightQ[$past(wtChQ)] == $past(wtNew))
		else $error("weight not updated");
	a_weight_out: assert property (modeBits[0] && activeQ[0] |=> outQ[0] == $past(geVec[0]))
		else $error("output 0 not following weight");
	a_io_byte: assert property (takeCmd && grp == `LCCH_READ_IO_CMD
		|=> txShiftQ[7:0] == {~$past(pinS2Q), $past(outQ)})
		else $error("io byte wrong");
	a_write_outs: assert property (oCommit && (modeBits & activeQ) == 4'h0
		|=> outQ == $past(rxByteQ[3:0]) && outFullQ && outByteQ == 8'h00)
		else $error("outputs not written");
	a_filter_bad: assert property (fCommit && !fValid |=> filtLenQ[$past(cCh)] == 4'h1)
		else $error("bad filter not forced to one");
	a_filter_purge: assert property (fCommit && newLen != filtLenQ[cCh]
		|=> fillQ[$past(cCh)] == 4'h0 && sumQ[$past(cCh)] == 27'h0
		&& !(wtPendQ && wtChQ == $past(cCh)))
		else $error("history not purged");
	a_active_save: assert property (aCommit |=> nvmSave && nvmSel && activeQ == $past(rxByteQ[3:0]))
		else $error("active flags not saved");
	a_in_clear: assert property ((takeCmd || takeData) && !hostWr |=> !inFullQ)
		else $error("input full not cleared");
	a_timeout_drop: assert property (timeout |=> stateQ == ST_IDLE && !outFullQ)
		else $error("timeout did not abandon");
	a_unknown_drop: assert property (takeCmd && txLen == 3'h0 && !isWr
		|=> stateQ == ST_IDLE && $stable(activeQ))
		else $error("unknown command acted");
	a_full_count: assert property (txLoad && txLeftQ == 3'h1 && !timeout
		|=> stateQ == ST_ACK ##1 (outFullQ or s_ack_sent))
		else $error("terminator sequence wrong");
endmodule

/* hw/lcch_hist_mem.sv */
`timescale 1ns/1ps
module lcch_hist_mem
	import lcch_pkg::*;
#(
	parameter int AW = 5,
	parameter int DW = 24
)
(
	// Clock
	input logic clk,
	// Write port
	input logic wrEn,
	input logic [AW-1:0] wrAddr,
	input logic [DW-1:0] wrData,
	// Read port, data one cycle after address
	input logic [AW-1:0] rdAddr,
	output logic [DW-1:0] rdData
);
	logic [DW-1:0] mem [2**AW];

	if (AW < 1 || DW < 1)
	begin : g_chk
		$error("lcch_hist_mem: bad size");
	end

	always_ff @(posedge clk)
	begin
		if (wrEn)
		begin
			mem[wrAddr] <= wrData;
		end
		rdData <= mem[rdAddr];
	end
endmodule

/* pkg/lcch_pkg.sv */
package lcch_pkg;
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'h0,
		ST_TX = 2'h1,
		ST_ACK = 2'h3,
		ST_RX = 2'h2
	} lcch_state_type;
	typedef logic [31:0] lcch_float_type;
endpackage

/* pkg/lcch_regs.svh */
`ifndef LCCH_REGS_SVH
`define LCCH_REGS_SVH
`define LCCH_OFS_DATA 8'h00
`define LCCH_OFS_STAT 8'h04
`define LCCH_STAT_INFULL 0
`define LCCH_STAT_OUTFULL 1
`define LCCH_STAT_BUSY 2
`define LCCH_READ_WEIGHT_CMD 8'h70
`define LCCH_READ_FILTERED_SAMPLE_CMD 8'h74
`define LCCH_READ_FILTER_LENGTH_CMD 8'h78
`define LCCH_WRITE_FILTER_LENGTH_CMD 8'h7C
`define LCCH_READ_OUTPUT_CONTROL_CMD 8'h80
`define LCCH_READ_IO_CMD 8'h4C
`define LCCH_WRITE_OUTPUTS_CMD 8'h50
`define LCCH_READ_CHANNEL_ACTIVE_CMD 8'h54
`define LCCH_WRITE_CHANNEL_ACTIVE_CMD 8'h58
`define LCCH_LEN_WEIGHT 3'h4
`define LCCH_LEN_SAMPLE 3'h3
`define LCCH_LEN_BYTE 3'h1
`define LCCH_ACK_BYTE 8'h00
`define LCCH_FILT_RST 4'h1
`define LCCH_ACT_RST 4'hF
`define LCCH_NVM_FILT 1'b0
`define LCCH_NVM_ACT 1'b1
`define LCCH_TIMEOUT_US 750
`define LCCH_CLK_NS 10
`endif

/* testbench/lcch_host_model.sv */
`timescale 1ns/1ps
`include "lcch_regs.svh"
module lcch_host_model
(
	// Clock
	input wire logic clk,
	// AHB-Lite master side
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata
);
	initial
	begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	// One single word transfer; data lines carry garbage outside the data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		n = 0;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= w;
		hsize <= 3'h2;
		hwdata <= ~hwdata;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (hready !== 1'b1 && n < 100);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (hready !== 1'b1 && n < 200);
		rd = hrdata;
	endtask
	// Wait for the device to take the previous byte, giving up after 50 status reads
	task automatic put_byte(input logic [7:0] b);
		logic [31:0] s;
		int n;
		n = 0;
		do
		begin
			bus(1'b0, `LCCH_OFS_STAT, 32'h0, s);
			n++;
		end
		while (s[`LCCH_STAT_INFULL] !== 1'b0 && n < 50);
		bus(1'b1, `LCCH_OFS_DATA, {24'h000000, b}, s);
	endtask
	// A byte that never shows up comes back unknown so the caller flags it
	task automatic get_byte(output logic [7:0] b);
		logic [31:0] s;
		int n;
		n = 0;
		do
		begin
			bus(1'b0, `LCCH_OFS_STAT, 32'h0, s);
			n++;
		end
		while (s[`LCCH_STAT_OUTFULL] !== 1'b1 && n < 20);
		b = 8'hXX;
		if (s[`LCCH_STAT_OUTFULL] === 1'b1)
		begin
			bus(1'b0, `LCCH_OFS_DATA, 32'h0, s);
			b = s[7:0];
		end
	endtask
endmodule

/* testbench/load_cell_channel_command_handler_test.sv */
`timescale 1ns/1ps
module load_cell_channel_command_handler_test
	import lcch_pkg::*;
;
	logic clk, rst_b, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans, sampleCh, nvmCh;
	logic [2:0] hsize;
	logic sampleValid, nvmSave, nvmSel;
	logic [23:0] sampleData;
	logic [3:0][31:0] calScale, calK, calZero, setpoint;
	logic [3:0] modeBits, inPins, outPins;
	logic [7:0] nvmData;
	logic [10:0] lastNvm;
	int miscompares, n_compared, cycles, saves;
	assign hready = hreadyout;
	lcch_cmd_handler #(.TIMEOUT_CYCLES(50)) u_dut (.clk(clk), .rst_b(rst_b), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.sampleValid(sampleValid), .sampleCh(sampleCh), .sampleData(sampleData),
		.calScale(calScale), .calK(calK), .calZero(calZero), .setpoint(setpoint),
		.modeBits(modeBits), .inPins(inPins), .outPins(outPins), .nvmSave(nvmSave),
		.nvmSel(nvmSel), .nvmCh(nvmCh), .nvmData(nvmData));
	lcch_host_model u_host (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		if (nvmSave === 1'b1)
		begin
			saves++;
			lastNvm = {nvmSel, nvmCh, nvmData};
		end
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("Compared %0d, miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
			miscompares++;
		end
	endtask
	// Read command: n data bytes least significant first, then the zero byte
	task automatic cmd_read(input logic [7:0] c, input int n, output logic [31:0] v);
		logic [7:0] b;
		v = 32'h0;
		u_host.put_byte(c);
		for (int i = 0; i < n; i++)
		begin
			u_host.get_byte(b);
			v[8*i+:8] = b;
		end
		u_host.get_byte(b);
		check("terminator", 32'h0, {24'h0, b});
	endtask
	task automatic cmd_write(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] b;
		u_host.put_byte(c);
		u_host.put_byte(d);
		u_host.get_byte(b);
		check("write ack", 32'h0, {24'h0, b});
	endtask
	// Samples of one channel stay a few cycles apart
	task automatic feed(input logic [1:0] ch, input logic [23:0] d);
		sampleValid <= 1'b1;
		sampleCh <= ch;
		sampleData <= d;
		@(posedge clk);
		sampleValid <= 1'b0;
		sampleData <= ~d;
		repeat (4) @(posedge clk);
	endtask
	task automatic t_io();
		logic [31:0] v;
		inPins <= 4'h3;
		cmd_write(8'h50, 8'hFA);
		check("outputs", 32'hA, {28'h0, outPins});
		cmd_read(8'h4C, 1, v);
		check("io byte", 32'hCA, v);
	endtask
	task automatic t_filter();
		logic [31:0] v;
		logic [7:0] val[6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h03, 8'h10};
		logic [7:0] exp[6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h01, 8'h01};
		int s0;
		s0 = saves;
		for (int i = 0; i < 6; i++)
		begin
			cmd_write(8'h7D, val[i]);
			check("saved filter", {21'h0, 1'b0, 2'h1, exp[i]}, {21'h0, lastNvm});
			cmd_read(8'h79, 1, v);
			check("filter length", {24'h0, exp[i]}, v);
		end
		check("save pulses", 32'd6, saves - s0);
	endtask
	task automatic t_sample();
		logic [31:0] v;
		cmd_write(8'h7C, 8'h01);
		feed(2'h0, 24'h123456);
		cmd_read(8'h74, 3, v);
		check("sample", 32'h00123456, v);
		cmd_write(8'h7C, 8'h02);
		feed(2'h0, 24'h000010);
		cmd_read(8'h74, 3, v);
		check("stale sample", 32'h00123456, v);
		feed(2'h0, 24'h000030);
		cmd_read(8'h74, 3, v);
		check("average", 32'h00000020, v);
	endtask
	task automatic t_weight();
		logic [31:0] v;
		cmd_read(8'h70, 4, v);
		check("weight", 32'h42000000, v);
		modeBits <= 4'h1;
		cmd_read(8'h80, 1, v);
		check("mode", 32'h1, v);
		check("weighted output", 32'hB, {28'h0, outPins});
		cmd_write(8'h58, 8'h0E);
		check("saved flags", {21'h0, 1'b1, 2'h0, 8'h0E}, {21'h0, lastNvm});
		cmd_read(8'h54, 1, v);
		check("active flags", 32'hE, {28'h0, v[3:0]});
		cmd_write(8'h50, 8'h00);
		check("inactive output", 32'h0, {28'h0, outPins});
	endtask
	task automatic t_unknown();
		logic [31:0] s;
		u_host.put_byte(8'h99);
		repeat (4) @(posedge clk);
		u_host.bus(1'b0, 8'h04, 32'h0, s);
		check("idle after unknown", 32'h0, s);
		check("outputs kept", 32'h0, {28'h0, outPins});
	endtask
	task automatic t_abort();
		logic [31:0] s;
		logic [7:0] b;
		u_host.put_byte(8'h74);
		u_host.get_byte(b);
		repeat (60) @(posedge clk);
		u_host.bus(1'b0, 8'h04, 32'h0, s);
		check("abandoned", 32'h0, s);
		cmd_read(8'h78, 1, s);
		check("after abort", 32'h2, s);
	endtask
	initial
	begin
		logic [31:0] v;
		rst_b = 1'b0;
		sampleValid = 1'b0;
		sampleCh = 2'h0;
		sampleData = 24'h0;
		calScale = {4{32'h3F800000}};
		calK = {4{32'h40000000}};
		calZero = {4{32'h00000010}};
		setpoint = {4{32'h41800000}};
		modeBits = 4'h0;
		inPins = 4'hF;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		check("ready", 32'h1, {31'h0, hreadyout});
		check("okay", 32'h0, {31'h0, hresp});
		cmd_read(8'h78, 1, v);
		check("filter reset", 32'h1, v);
		t_io();
		t_filter();
		t_sample();
		t_weight();
		t_unknown();
		t_abort();
		cmd_write(8'h50, 8'h0F);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		check("outputs after reset", 32'h0, {28'h0, outPins});
		cmd_read(8'h54, 1, v);
		check("active reset", 32'hF, {28'h0, v[3:0]});
		finish_test();
	end
endmodule
